// ### src/iptc_pkg.sv
// Package for the interrupt priority, trap status and request flag block.
// Assumes a single system clock domain and a plain strobe register port.
package iptc_pkg;
    // Register offsets (word index on the plain register port)
    localparam logic [3:0] IPTC_OFF_STATUS = 4'h0;
    localparam logic [3:0] IPTC_OFF_CORE = 4'h1;
    localparam logic [3:0] IPTC_OFF_TRAPCTL = 4'h2;
    localparam logic [3:0] IPTC_OFF_VECCTL = 4'h3;
    localparam logic [3:0] IPTC_OFF_FLAGS0 = 4'h4;
    localparam logic [3:0] IPTC_OFF_EVSTAT = 4'h5;
    localparam logic [3:0] IPTC_OFF_EVMASK = 4'h6;
    // Field positions
    localparam int IPTC_POS_PRIO_LO = 5;
    localparam int IPTC_POS_PRIO_MSB = 3;
    localparam int IPTC_POS_NEST_DIS = 15;
    localparam int IPTC_POS_ACCA_OVF = 14;
    localparam int IPTC_POS_ACCB_OVF = 13;
    localparam int IPTC_POS_ACCA_CAT = 12;
    localparam int IPTC_POS_ACCB_CAT = 11;
    localparam int IPTC_POS_ACCA_TE = 10;
    localparam int IPTC_POS_ACCB_TE = 9;
    localparam int IPTC_POS_CAT_TE = 8;
    localparam int IPTC_POS_DMA_FLT = 5;
    localparam int IPTC_POS_ADDR_FLT = 3;
    localparam int IPTC_POS_STK_FLT = 2;
    localparam int IPTC_POS_OSC_FLT = 1;
    localparam int IPTC_POS_ALT_TBL = 15;
    localparam int IPTC_NUM_EXT = 3;
    localparam int IPTC_NUM_SRC = 15;
    // Writable masks and reset values
    localparam logic [15:0] IPTC_TRAPCTL_WMASK = 16'hFF2E;
    localparam logic [15:0] IPTC_VECCTL_WMASK = 16'h8007;
    localparam logic [15:0] IPTC_FLAGS0_WMASK = 16'h7FFF;
    localparam logic [15:0] IPTC_RST_WORD = 16'h0000;
    localparam logic [2:0] IPTC_PRIO_BLOCK = 3'h7;

    // Trap events from core and peripherals
    typedef struct packed {
        logic acc_a_ovf;
        logic acc_b_ovf;
        logic acc_a_cat;
        logic acc_b_cat;
        logic dma_fault;
        logic addr_fault;
        logic stk_fault;
        logic osc_fault;
    } iptc_trap_type;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } iptc_bus_type;

    // Whole block state
    typedef struct packed {
        logic [2:0] prio_lo;
        logic prio_msb;
        logic [15:0] trapctl;
        logic [15:0] vecctl;
        logic [15:0] flags0;
        logic [7:0] evstat;
        logic [7:0] evmask;
        logic [2:0] ext_s1;
        logic [2:0] ext_s2;
        logic [2:0] ext_s3;
        logic [2:0] ext_last;
        logic [15:0] rdata;
    } iptc_state_type;
endpackage

// ### src/iptc_core.sv
// Interrupt priority level, trap status and request flag group 0.
// Assumes software drives a one-cycle strobe port; external inputs are asynchronous pins.
// Functional notes
// - Status word bits 7..5 hold writable priority
// - Priority msb in core word is read-only
// - Priority level is msb concatenated with low field
// - Level seven or msb set blocks user interrupts
// - Nesting disable makes low priority bits read-only
// - Bits 14..11 record accumulator overflow causes
// - Bits 3,2,1 record address, stack, oscillator traps
// - Polarity bit picks negative or positive edge
// - Flag group maps sources from bit 0
// - Flag one means request raised; reset zero
// - Unimplemented bits always read zero
// - Control selects alternate or standard vector table
// - Flags set by sources, cleared only by software
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module iptc_core
    import iptc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [IPTC_NUM_EXT-1:0] ext_pin_in,
    input wire logic [IPTC_NUM_SRC-1:0] src_req_in,
    input wire iptc_trap_type trap_in,
    input wire logic prio_set_in,
    input wire logic [3:0] prio_val_in,
    output logic [3:0] cpu_prio_out,
    output logic user_irq_block_out,
    output logic nesting_disable_out,
    output logic alt_table_select_out,
    output logic [2:0] acc_trap_take_out,
    output logic [15:0] pending_flags_out,
    output logic irq_out
);
    iptc_state_type st_r;
    iptc_state_type st_nxt;
    iptc_bus_type bus;
    logic [15:0] src_set;
    logic [IPTC_NUM_EXT-1:0] ext_edge;
    logic [7:0] trap_vec;

    // Write decode helper, used for every writable register
    function automatic logic wr_hit(input iptc_bus_type b, input logic [3:0] off);
        wr_hit = b.wr && (b.addr == off);
    endfunction

    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    assign trap_vec = trap_in;

    // Edge detect on synchronised pins, polarity chosen per input
    generate
        for (genvar i = 0; i < IPTC_NUM_EXT; i++) begin : g_ext
            assign ext_edge[i] = (st_r.ext_s2[i] == st_r.ext_s3[i]) &&
                (st_r.ext_s3[i] != st_r.ext_last[i]) &&
                (st_r.vecctl[i] ? !st_r.ext_s3[i] : st_r.ext_s3[i]);
        end
    endgenerate

    // External input 0 and source 0 share bit 0, sources 14..1 in bits 14..1, bit 15 never set
    assign src_set = {1'b0, src_req_in[14:1], src_req_in[0] | ext_edge[0]};

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.ext_s1 = ext_pin_in;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        if (st_r.ext_s2 == st_r.ext_s3) begin
            st_nxt.ext_last = st_r.ext_s3;
        end
        // Core priority updates; software writes ignored while nesting is off
        if (prio_set_in) begin
            st_nxt.prio_lo = prio_val_in[2:0];
            st_nxt.prio_msb = prio_val_in[3];
        end else if (wr_hit(bus, IPTC_OFF_STATUS) && !st_r.trapctl[IPTC_POS_NEST_DIS]) begin
            st_nxt.prio_lo = bus.wdata[IPTC_POS_PRIO_LO +: 3];
        end
        // Software writes first, hardware sets win afterwards
        if (wr_hit(bus, IPTC_OFF_TRAPCTL)) begin
            st_nxt.trapctl = bus.wdata & IPTC_TRAPCTL_WMASK;
        end
        st_nxt.trapctl[IPTC_POS_ACCA_OVF] = st_nxt.trapctl[IPTC_POS_ACCA_OVF] | trap_in.acc_a_ovf;
        st_nxt.trapctl[IPTC_POS_ACCB_OVF] = st_nxt.trapctl[IPTC_POS_ACCB_OVF] | trap_in.acc_b_ovf;
        st_nxt.trapctl[IPTC_POS_ACCA_CAT] = st_nxt.trapctl[IPTC_POS_ACCA_CAT] | trap_in.acc_a_cat;
        st_nxt.trapctl[IPTC_POS_ACCB_CAT] = st_nxt.trapctl[IPTC_POS_ACCB_CAT] | trap_in.acc_b_cat;
        st_nxt.trapctl[IPTC_POS_DMA_FLT] = st_nxt.trapctl[IPTC_POS_DMA_FLT] | trap_in.dma_fault;
        st_nxt.trapctl[IPTC_POS_ADDR_FLT] = st_nxt.trapctl[IPTC_POS_ADDR_FLT] | trap_in.addr_fault;
        st_nxt.trapctl[IPTC_POS_STK_FLT] = st_nxt.trapctl[IPTC_POS_STK_FLT] | trap_in.stk_fault;
        st_nxt.trapctl[IPTC_POS_OSC_FLT] = st_nxt.trapctl[IPTC_POS_OSC_FLT] | trap_in.osc_fault;
        if (wr_hit(bus, IPTC_OFF_VECCTL)) begin
            st_nxt.vecctl = bus.wdata & IPTC_VECCTL_WMASK;
        end
        if (wr_hit(bus, IPTC_OFF_FLAGS0)) begin
            st_nxt.flags0 = bus.wdata & IPTC_FLAGS0_WMASK;
        end
        st_nxt.flags0 = st_nxt.flags0 | src_set;
        if (wr_hit(bus, IPTC_OFF_EVMASK)) begin
            st_nxt.evmask = bus.wdata[7:0];
        end
        // Sticky events, cleared by a read, a new event wins
        if (bus.rd && bus.addr == IPTC_OFF_EVSTAT) begin
            st_nxt.evstat = 8'h00;
        end
        st_nxt.evstat = st_nxt.evstat | trap_vec;
        // Read data, registered for the following cycle
        st_nxt.rdata = 16'h0000;
        if (bus.rd) begin
            case (bus.addr)
                IPTC_OFF_STATUS: st_nxt.rdata = {8'h00, st_r.prio_lo, 5'h00};
                IPTC_OFF_CORE: st_nxt.rdata = {12'h000, st_r.prio_msb, 3'h0};
                IPTC_OFF_TRAPCTL: st_nxt.rdata = st_r.trapctl;
                IPTC_OFF_VECCTL: st_nxt.rdata = st_r.vecctl;
                IPTC_OFF_FLAGS0: st_nxt.rdata = st_r.flags0;
                IPTC_OFF_EVSTAT: st_nxt.rdata = {8'h00, st_r.evstat};
                IPTC_OFF_EVMASK: st_nxt.rdata = {8'h00, st_r.evmask};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign cpu_prio_out = {st_r.prio_msb, st_r.prio_lo};
    assign user_irq_block_out = st_r.prio_msb || (st_r.prio_lo == IPTC_PRIO_BLOCK);
    assign nesting_disable_out = st_r.trapctl[IPTC_POS_NEST_DIS];
    assign alt_table_select_out = st_r.vecctl[IPTC_POS_ALT_TBL];
    assign acc_trap_take_out = {
        st_r.trapctl[IPTC_POS_CAT_TE] &
            (st_r.trapctl[IPTC_POS_ACCA_CAT] | st_r.trapctl[IPTC_POS_ACCB_CAT]),
        st_r.trapctl[IPTC_POS_ACCB_TE] & st_r.trapctl[IPTC_POS_ACCB_OVF],
        st_r.trapctl[IPTC_POS_ACCA_TE] & st_r.trapctl[IPTC_POS_ACCA_OVF]};
    assign pending_flags_out = st_r.flags0;
    assign reg_rdata_out = st_r.rdata;
    assign irq_out = |(st_r.evstat & st_r.evmask);

    // Assertions
    chk_prio_write_locked: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_hit(bus, IPTC_OFF_STATUS) && st_r.trapctl[IPTC_POS_NEST_DIS] && !prio_set_in)
        |=> $stable(cpu_prio_out[2:0])) else $error("priority changed while locked");
    chk_prio_write_takes: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_hit(bus, IPTC_OFF_STATUS) && !st_r.trapctl[IPTC_POS_NEST_DIS] && !prio_set_in)
        |=> cpu_prio_out[2:0] == $past(reg_wdata_in[7:5])) else $error("priority write lost");
    chk_msb_sw_readonly: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !prio_set_in |=> $stable(cpu_prio_out[3])) else $error("priority msb changed");
    chk_block_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cpu_prio_out >= 4'h7) == user_irq_block_out) else $error("block level wrong");
    chk_dma_fault_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.dma_fault |=> st_r.trapctl[IPTC_POS_DMA_FLT]) else $error("dma flag missed");
    chk_flags_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!wr_hit(bus, IPTC_OFF_FLAGS0))
        |=> ((st_r.flags0 & $past(st_r.flags0)) == $past(st_r.flags0)))
        else $error("flag cleared by hardware");
    chk_flag_bit15_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_r.flags0[15] && !st_r.trapctl[0]) else $error("unused bit set");
    chk_read_latency: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (bus.rd && bus.addr == IPTC_OFF_FLAGS0 && !bus.wr) |=> reg_rdata_out == $past(st_r.flags0))
        else $error("flag read wrong");
    chk_ext_edge_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ext_edge[0] |=> pending_flags_out[0]) else $error("edge flag missed");
    cov_nest_lock: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        wr_hit(bus, IPTC_OFF_STATUS) && st_r.trapctl[IPTC_POS_NEST_DIS]);
    cov_irq: cover property (@(posedge clk_sys_in) disable iff (rst_in) irq_out);
    cov_acc_trap: cover property (@(posedge clk_sys_in) disable iff (rst_in) |acc_trap_take_out);

    // Control writes land in the cycle after the strobe
    chk_nest_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        wr_hit(bus, IPTC_OFF_TRAPCTL)
        |=> nesting_disable_out == $past(reg_wdata_in[IPTC_POS_NEST_DIS]))
        else $error("nesting disable write lost");

    chk_alt_table_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        wr_hit(bus, IPTC_OFF_VECCTL)
        |=> alt_table_select_out == $past(reg_wdata_in[IPTC_POS_ALT_TBL]))
        else $error("table select write lost");

    chk_edge_pol_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        wr_hit(bus, IPTC_OFF_VECCTL)
        |=> st_r.vecctl[2:0] == $past(reg_wdata_in[2:0]))
        else $error("edge polarity write lost");

    // Core priority load and the blocking level
    chk_core_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        prio_set_in
        |=> cpu_prio_out == $past(prio_val_in))
        else $error("core priority load lost");

    chk_msb_blocks: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        cpu_prio_out[3]
        |-> user_irq_block_out)
        else $error("high level not blocking");

    // Unused positions never hold a one
    chk_trap_write_mask: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_r.trapctl & ~IPTC_TRAPCTL_WMASK)
        == 16'h0000)
        else $error("unused trap control bit set");

    chk_vec_write_mask: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_r.vecctl & ~IPTC_VECCTL_WMASK)
        == 16'h0000)
        else $error("unused vector control bit set");

    chk_core_read_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (bus.rd && bus.addr == IPTC_OFF_CORE)
        |=> (reg_rdata_out & 16'hFFF7) == 16'h0000)
        else $error("core word read not clean");

    chk_status_read_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (bus.rd && bus.addr == IPTC_OFF_STATUS)
        |=> (reg_rdata_out & 16'hFF1F) == 16'h0000)
        else $error("status word read not clean");

    chk_read_idle_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !bus.rd
        |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read slot");

    // Trap causes are recorded one cycle after the event
    chk_acc_a_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.acc_a_ovf
        |=> st_r.trapctl[IPTC_POS_ACCA_OVF])
        else $error("acc a overflow missed");

    chk_acc_b_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.acc_b_ovf
        |=> st_r.trapctl[IPTC_POS_ACCB_OVF])
        else $error("acc b overflow missed");

    chk_cat_a_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.acc_a_cat
        |=> st_r.trapctl[IPTC_POS_ACCA_CAT])
        else $error("acc a catastrophic missed");

    chk_cat_b_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.acc_b_cat
        |=> st_r.trapctl[IPTC_POS_ACCB_CAT])
        else $error("acc b catastrophic missed");

    chk_addr_fault_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.addr_fault
        |=> st_r.trapctl[IPTC_POS_ADDR_FLT])
        else $error("address fault missed");

    chk_stack_fault_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.stk_fault
        |=> st_r.trapctl[IPTC_POS_STK_FLT])
        else $error("stack fault missed");

    chk_osc_fault_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_in.osc_fault
        |=> st_r.trapctl[IPTC_POS_OSC_FLT])
        else $error("oscillator fault missed");

    // Request flags: set by sources, cleared only by a write
    chk_src_flag_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (|src_req_in)
        |=> (pending_flags_out[14:0] & $past(src_req_in)) == $past(src_req_in))
        else $error("source request not flagged");

    chk_flag_sw_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_hit(bus, IPTC_OFF_FLAGS0) && src_req_in == '0 && !ext_edge[0])
        |=> pending_flags_out == ($past(reg_wdata_in) & IPTC_FLAGS0_WMASK))
        else $error("flag write not applied");

    // No trap is taken while its enable is clear
    chk_take_a_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_r.trapctl[IPTC_POS_ACCA_TE]
        |-> !acc_trap_take_out[0])
        else $error("acc a trap taken while off");

    chk_take_b_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_r.trapctl[IPTC_POS_ACCB_TE]
        |-> !acc_trap_take_out[1])
        else $error("acc b trap taken while off");

    chk_take_cat_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_r.trapctl[IPTC_POS_CAT_TE]
        |-> !acc_trap_take_out[2])
        else $error("catastrophic trap taken while off");

    // Sticky event bits: a new event beats the clearing read
    chk_event_set_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        trap_vec != 8'h00
        |=> (st_r.evstat & $past(trap_vec)) == $past(trap_vec))
        else $error("trap event lost");

    chk_event_read_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (bus.rd && bus.addr == IPTC_OFF_EVSTAT && trap_vec == 8'h00)
        |=> st_r.evstat == 8'h00)
        else $error("event status not cleared");

    // Edge on external input 0 and a core load into the upper levels
    cov_ext_edge: cover property (@(posedge clk_sys_in) disable iff (rst_in) ext_edge[0]);
    cov_core_load: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        prio_set_in && prio_val_in[3]);
endmodule

// ### sim/iptc_src_model.sv
// Behavioural core and peripheral sources: trap pulses, request pulses, pins, priority loads.
// Assumes the bench calls these tasks from one process, one request at a time.
`timescale 1ns/100ps
module iptc_src_model
    import iptc_pkg::*;
(
    input wire logic clk_sys_in,
    output logic [IPTC_NUM_EXT-1:0] ext_pin_out,
    output logic [IPTC_NUM_SRC-1:0] src_req_out,
    output iptc_trap_type trap_out,
    output logic prio_set_out,
    output logic [3:0] prio_val_out
);
    // Quiet sources at start
    initial begin
        ext_pin_out = '0;
        src_req_out = '0;
        trap_out = '0;
        prio_set_out = 1'b0;
        prio_val_out = 4'hF;
    end
    // One-cycle set pulses; sources only ever set, never clear
    task automatic pulse(input logic [14:0] src, input logic [7:0] trp);
        @(posedge clk_sys_in);
        src_req_out <= src;
        trap_out <= trp;
        @(posedge clk_sys_in);
        src_req_out <= '0;
        trap_out <= '0;
        #1;
    endtask
    // Core priority load; value line shows garbage once released
    task automatic load_prio(input logic [3:0] v);
        @(posedge clk_sys_in);
        prio_set_out <= 1'b1;
        prio_val_out <= v;
        @(posedge clk_sys_in);
        prio_set_out <= 1'b0;
        prio_val_out <= ~v;
        #1;
    endtask
    // External pin levels, changed right after an edge
    task automatic pins(input logic [2:0] v);
        @(posedge clk_sys_in);
        ext_pin_out <= v;
    endtask
endmodule

// ### sim/interrupt_priority_trap_status_tb_top.sv
// Self-checking bench for the priority, trap status and request flag block.
// Assumes the strobe register port with read data one cycle after the strobe.
`timescale 1ns/100ps
module interrupt_priority_trap_status_tb_top
    import iptc_pkg::*;
;
    logic clk_sys_in, rst_in, wr, rd, prio_set, blk, nest, alt, irq;
    logic [3:0] addr, prio_val, prio;
    logic [15:0] wdata, rdata, rv, pend;
    logic [2:0] ext, take;
    logic [14:0] req;
    iptc_trap_type trap;
    int miscompares, tests_run;
    int pos[8] = '{14, 13, 12, 11, 5, 3, 2, 1};
    iptc_core dut(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .ext_pin_in(ext), .src_req_in(req), .trap_in(trap), .prio_set_in(prio_set),
        .prio_val_in(prio_val), .cpu_prio_out(prio), .user_irq_block_out(blk),
        .nesting_disable_out(nest), .alt_table_select_out(alt), .acc_trap_take_out(take),
        .pending_flags_out(pend), .irq_out(irq));
    iptc_src_model src(.clk_sys_in(clk_sys_in), .ext_pin_out(ext), .src_req_out(req),
        .trap_out(trap), .prio_set_out(prio_set), .prio_val_out(prio_val));
    // Clock at 20 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Bus cycles and comparisons
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        wdata <= ~d;
        #1;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_reg(input logic [3:0] a, input logic [15:0] exp);
        reg_read(a, rv);
        report(rv, exp);
    endtask
    task automatic check_pin(input logic [15:0] got, input logic [15:0] exp);
        report(got, exp);
    endtask
    // Drive pins, let the synchroniser settle, check flag bit 0, then clear flags
    task automatic ext_step(input logic [2:0] v, input logic exp);
        src.pins(v);
        repeat (10) @(posedge clk_sys_in);
        #1;
        check_pin({15'h0000, pend[0]}, {15'h0000, exp});
        reg_write(IPTC_OFF_FLAGS0, 16'h0000);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        test_done;
    end
    // Test sequence
    initial begin
        rst_in = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 8; a++) check_reg(a[3:0], 16'h0000);
        reg_write(IPTC_OFF_STATUS, 16'h00E0);
        check_pin({11'h000, blk, prio}, 16'h0017);
        reg_write(IPTC_OFF_STATUS, 16'h00C0);
        check_pin({11'h000, blk, prio}, 16'h0006);
        reg_write(IPTC_OFF_CORE, 16'h0008);
        check_reg(IPTC_OFF_CORE, 16'h0000);
        src.load_prio(4'h9);
        check_reg(IPTC_OFF_CORE, 16'h0008);
        check_reg(IPTC_OFF_STATUS, 16'h0020);
        check_pin({11'h000, blk, prio}, 16'h0019);
        src.load_prio(4'h0);
        reg_write(IPTC_OFF_TRAPCTL, 16'hFFFF);
        check_reg(IPTC_OFF_TRAPCTL, 16'hFF2E);
        check_pin({12'h000, nest, take}, 16'h000F);
        reg_write(IPTC_OFF_STATUS, 16'h00E0);
        check_reg(IPTC_OFF_STATUS, 16'h0000);
        reg_write(IPTC_OFF_TRAPCTL, 16'h4600);
        check_pin({12'h000, nest, take}, 16'h0001);
        reg_write(IPTC_OFF_TRAPCTL, 16'h7800);
        check_pin({13'h0000, take}, 16'h0000);
        reg_write(IPTC_OFF_STATUS, 16'h00A0);
        check_reg(IPTC_OFF_STATUS, 16'h00A0);
        for (int i = 0; i < 8; i++) begin
            reg_write(IPTC_OFF_TRAPCTL, 16'h0000);
            src.pulse(15'h0000, 8'h80 >> i);
            check_reg(IPTC_OFF_TRAPCTL, 16'h0001 << pos[i]);
        end
        check_reg(IPTC_OFF_EVSTAT, 16'h00FF);
        check_reg(IPTC_OFF_EVSTAT, 16'h0000);
        reg_write(IPTC_OFF_EVMASK, 16'h0001);
        src.pulse(15'h0000, 8'h02);
        check_pin({15'h0000, irq}, 16'h0000);
        src.pulse(15'h0000, 8'h01);
        check_pin({15'h0000, irq}, 16'h0001);
        check_reg(IPTC_OFF_EVSTAT, 16'h0003);
        check_pin({15'h0000, irq}, 16'h0000);
        reg_write(IPTC_OFF_VECCTL, 16'hFFFF);
        check_reg(IPTC_OFF_VECCTL, 16'h8007);
        check_pin({15'h0000, alt}, 16'h0001);
        reg_write(IPTC_OFF_VECCTL, 16'h0000);
        check_pin({15'h0000, alt}, 16'h0000);
        for (int i = 0; i < 15; i++) begin
            src.pulse(15'h0001 << i, 8'h00);
            check_reg(IPTC_OFF_FLAGS0, 16'hFFFF >> (15 - i));
        end
        check_pin(pend, 16'h7FFF);
        reg_write(IPTC_OFF_FLAGS0, 16'hFFFF);
        check_reg(IPTC_OFF_FLAGS0, 16'h7FFF);
        reg_write(IPTC_OFF_FLAGS0, 16'h0000);
        ext_step(3'b111, 1'b1);
        ext_step(3'b000, 1'b0);
        reg_write(IPTC_OFF_VECCTL, 16'h0007);
        ext_step(3'b111, 1'b0);
        ext_step(3'b000, 1'b1);
        test_done;
    end
endmodule
